// ===== design/toc_pkg.sv
// Package with register map, field layout, reset values and state carrier of the compare timer
// Function
// - Action field picks high, low, toggle, none
// - Initial-level bit presets the compare pin
// - Low byte pends until high byte written
// - Match applies action and raises compare interrupt
// - No-operation mode only raises the interrupt
// - Action 11 toggles the pin each match
// - Stopped counter forces compare output high
// - Three interrupt sources: top, capture, compare
// - Top interrupt at FFFFH, counting continues
// - Capture interrupt when capture register loads
package toc_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_MODE     = 8'h04;
    localparam logic [7:0] OFS_CMP_LO   = 8'h08;
    localparam logic [7:0] OFS_CMP_HI   = 8'h0C;
    localparam logic [7:0] OFS_COUNTER  = 8'h10;
    localparam logic [7:0] OFS_CAPTURE  = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;

    // Control register fields
    localparam int CTRL_RUN_BIT  = 0;
    localparam int CTRL_SRC_LSB  = 1;

    // Mode register fields
    localparam int MODE_ACT_LSB  = 0;
    localparam int MODE_INIT_BIT = 2;
    localparam int MODE_CAP_LSB  = 4;
    localparam int MODE_WEN_BIT  = 7;

    // Interrupt status and mask bit positions
    localparam int IRQ_TOP_BIT   = 0;
    localparam int IRQ_CAP_BIT   = 1;
    localparam int IRQ_CMP_BIT   = 2;

    // Compare action codes
    localparam logic [1:0] ACT_NOP    = 2'h0;
    localparam logic [1:0] ACT_HIGH   = 2'h1;
    localparam logic [1:0] ACT_LOW    = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    // Capture edge codes
    localparam logic [1:0] CAP_OFF  = 2'h0;
    localparam logic [1:0] CAP_RISE = 2'h1;
    localparam logic [1:0] CAP_FALL = 2'h2;
    localparam logic [1:0] CAP_BOTH = 2'h3;

    // Counter top value and reset values
    localparam logic [15:0] CNT_TOP       = 16'hFFFF;
    localparam logic [15:0] CMP_RESET     = 16'hFFFF;
    localparam logic        PIN_RESET     = 1'b1;
    localparam logic [1:0]  SRC_RESET     = 2'h0;

    // Prescaler width: tick every 2**src_sel clock cycles
    localparam int PRE_W = 3;

    // Whole state of the block
    typedef struct packed {
        logic             run;
        logic [1:0]       src_sel;
        logic [1:0]       action;
        logic             init_level;
        logic [1:0]       cap_edge;
        logic             init_wen;
        logic [7:0]       cmp_low_pend;
        logic [15:0]      cmp;
        logic [15:0]      cnt;
        logic [15:0]      cap;
        logic             cap_lock;
        logic [PRE_W-1:0] pre;
        logic             pin_level;
        logic [2:0]       irq_stat;
        logic [2:0]       irq_mask;
        logic             sync1;
        logic             sync2;
        logic             cap_prev;
        logic [31:0]      prdata;
    } toc_state_s;

endpackage : toc_pkg

// ===== design/toc_timer_compare.sv
// Output compare, capture and interrupt logic of a 16-bit free-running timer with an APB slave
`timescale 1ns/1ps
module toc_timer_compare (
    input  wire logic        CLK_I,
    input  wire logic        RSTN_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        CAPTURE_PIN_I,
    output logic             COMPARE_PIN_O,
    output logic             IRQ_O
);

    toc_pkg::toc_state_s st_reg;
    toc_pkg::toc_state_s st_next;

    logic        setup_phase;
    logic        wr_access;
    logic        addr_hit;
    logic        tick;
    logic [15:0] cnt_inc;
    logic        match;
    logic        top_hit;
    logic        edge_rise;
    logic        edge_fall;
    logic        cap_event;
    logic [2:0]  irq_events;
    logic [2:0]  irq_clear;
    logic [31:0] rd_mux;
    logic [toc_pkg::PRE_W-1:0] pre_mask;

    // Bus phase decode
    assign setup_phase = PSEL_I && !PENABLE_I;
    assign wr_access   = PSEL_I && PENABLE_I && PWRITE_I && addr_hit;

    // Zero-wait slave; unmapped addresses answer with an error
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_hit;
    assign PRDATA_O  = st_reg.prdata;

    // Address decode
    always_comb begin
        case (PADDR_I)
            toc_pkg::OFS_CTRL,
            toc_pkg::OFS_MODE,
            toc_pkg::OFS_CMP_LO,
            toc_pkg::OFS_CMP_HI,
            toc_pkg::OFS_COUNTER,
            toc_pkg::OFS_CAPTURE,
            toc_pkg::OFS_IRQ_STAT,
            toc_pkg::OFS_IRQ_MASK: addr_hit = 1'b1;
            default:               addr_hit = 1'b0;
        endcase
    end

    // Read data mux, sampled in the setup phase so the data comes from a flop
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (PADDR_I)
            toc_pkg::OFS_CTRL: begin
                rd_mux[toc_pkg::CTRL_RUN_BIT] = st_reg.run;
                rd_mux[toc_pkg::CTRL_SRC_LSB +: 2] = st_reg.src_sel;
            end
            toc_pkg::OFS_MODE: begin
                rd_mux[toc_pkg::MODE_ACT_LSB +: 2] = st_reg.action;
                rd_mux[toc_pkg::MODE_INIT_BIT]     = st_reg.init_level;
                rd_mux[toc_pkg::MODE_CAP_LSB +: 2] = st_reg.cap_edge;
                rd_mux[toc_pkg::MODE_WEN_BIT]      = st_reg.init_wen;
            end
            toc_pkg::OFS_CMP_LO:   rd_mux[7:0]  = st_reg.cmp_low_pend;
            toc_pkg::OFS_CMP_HI:   rd_mux[15:0] = st_reg.cmp;
            toc_pkg::OFS_COUNTER:  rd_mux[15:0] = st_reg.cnt;
            toc_pkg::OFS_CAPTURE:  rd_mux[15:0] = st_reg.cap;
            toc_pkg::OFS_IRQ_STAT: rd_mux[2:0]  = st_reg.irq_stat;
            toc_pkg::OFS_IRQ_MASK: rd_mux[2:0]  = st_reg.irq_mask;
            default:               rd_mux       = 32'h0000_0000;
        endcase
    end

    // Counter tick from the prescaler; low src_sel bits of pre must be all ones
    assign pre_mask = toc_pkg::PRE_W'((1 << st_reg.src_sel) - 1);
    assign tick     = st_reg.run && ((st_reg.pre & pre_mask) == pre_mask);
    assign cnt_inc  = st_reg.cnt + 16'h0001;

    // Match only on a counting update, so a static equality fires once
    assign match   = tick && (cnt_inc == st_reg.cmp);
    assign top_hit = tick && (cnt_inc == toc_pkg::CNT_TOP);

    // Edge detect on the second and third synchroniser stages only
    assign edge_rise = st_reg.sync2 && !st_reg.cap_prev;
    assign edge_fall = !st_reg.sync2 && st_reg.cap_prev;
    always_comb begin
        case (st_reg.cap_edge)
            toc_pkg::CAP_RISE: cap_event = edge_rise;
            toc_pkg::CAP_FALL: cap_event = edge_fall;
            toc_pkg::CAP_BOTH: cap_event = edge_rise || edge_fall;
            default:           cap_event = 1'b0;
        endcase
    end

    // Interrupt events and write-one-to-clear
    always_comb begin
        irq_events = 3'h0;
        irq_events[toc_pkg::IRQ_TOP_BIT] = top_hit;
        irq_events[toc_pkg::IRQ_CAP_BIT] = cap_event && !st_reg.cap_lock;
        irq_events[toc_pkg::IRQ_CMP_BIT] = match;
        irq_clear = 3'h0;
        if (wr_access && PADDR_I == toc_pkg::OFS_IRQ_STAT) begin
            irq_clear = PWDATA_I[2:0];
        end
    end

    // Level interrupt while any unmasked status bit is set
    assign IRQ_O = |(st_reg.irq_stat & st_reg.irq_mask);

    // Pin is forced high while the counter is stopped
    assign COMPARE_PIN_O = st_reg.run ? st_reg.pin_level : 1'b1;

    // Next-state logic
    always_comb begin
        st_next = st_reg;

        // Two-flop synchroniser for the capture pin, then edge history
        st_next.sync1    = CAPTURE_PIN_I;
        st_next.sync2    = st_reg.sync1;
        st_next.cap_prev = st_reg.sync2;

        // Prescaler runs only with the counter so restarts are aligned
        if (st_reg.run) begin
            st_next.pre = st_reg.pre + toc_pkg::PRE_W'(1);
        end else begin
            st_next.pre = '0;
        end

        // Free-running count wraps past the top value
        if (tick) begin
            st_next.cnt = cnt_inc;
        end

        // Compare action on a match
        if (match) begin
            case (st_reg.action)
                toc_pkg::ACT_HIGH:   st_next.pin_level = 1'b1;
                toc_pkg::ACT_LOW:    st_next.pin_level = 1'b0;
                toc_pkg::ACT_TOGGLE: st_next.pin_level = !st_reg.pin_level;
                default:             st_next.pin_level = st_reg.pin_level;
            endcase
        end

        // Capture load; further captures held off until the value is read
        if (cap_event && !st_reg.cap_lock) begin
            st_next.cap      = st_reg.cnt;
            st_next.cap_lock = 1'b1;
        end

        // Read data and capture release in the setup phase
        if (setup_phase) begin
            st_next.prdata = rd_mux;
            if (!PWRITE_I && PADDR_I == toc_pkg::OFS_CAPTURE) begin
                st_next.cap_lock = 1'b0;
            end
        end

        // Register writes take effect in the access phase
        if (wr_access) begin
            case (PADDR_I)
                toc_pkg::OFS_CTRL: begin
                    st_next.run     = PWDATA_I[toc_pkg::CTRL_RUN_BIT];
                    st_next.src_sel = PWDATA_I[toc_pkg::CTRL_SRC_LSB +: 2];
                end
                toc_pkg::OFS_MODE: begin
                    st_next.action     = PWDATA_I[toc_pkg::MODE_ACT_LSB +: 2];
                    st_next.init_level = PWDATA_I[toc_pkg::MODE_INIT_BIT];
                    st_next.cap_edge   = PWDATA_I[toc_pkg::MODE_CAP_LSB +: 2];
                    st_next.init_wen   = PWDATA_I[toc_pkg::MODE_WEN_BIT];
                    // Preset only with the enable set; a match in this cycle loses
                    if (PWDATA_I[toc_pkg::MODE_WEN_BIT]) begin
                        st_next.pin_level = PWDATA_I[toc_pkg::MODE_INIT_BIT];
                    end
                end
                // Low byte waits; high byte commits the whole word
                toc_pkg::OFS_CMP_LO: st_next.cmp_low_pend = PWDATA_I[7:0];
                toc_pkg::OFS_CMP_HI: st_next.cmp = {PWDATA_I[7:0], st_reg.cmp_low_pend};
                toc_pkg::OFS_COUNTER: st_next.cnt = PWDATA_I[15:0];
                toc_pkg::OFS_IRQ_MASK: st_next.irq_mask = PWDATA_I[2:0];
                default: st_next.run = st_reg.run;
            endcase
        end

        // Sticky status: a new event wins over a clear in the same cycle
        st_next.irq_stat = (st_reg.irq_stat & ~irq_clear) | irq_events;
    end

    // State register
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st_reg              <= '0;
            st_reg.src_sel      <= toc_pkg::SRC_RESET;
            st_reg.cmp          <= toc_pkg::CMP_RESET;
            st_reg.pin_level    <= toc_pkg::PIN_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : toc_timer_compare

// ===== verif/toc_timer_compare_asserts.sv
// Checker of bus answers, compare pin and interrupt line of the compare timer
`timescale 1ns/1ps
module toc_timer_compare_asserts (
    input wire logic        CLK_I,
    input wire logic        RSTN_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [7:0]  PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        CAPTURE_PIN_I,
    input wire logic        COMPARE_PIN_O,
    input wire logic        IRQ_O
);
    logic       acc;
    logic       wr;
    logic       mapped;
    logic       run_reg;
    logic [2:0] mask_reg;
    // Access phase decode; map is word aligned up to the mask register
    assign acc    = PSEL_I && PENABLE_I;
    assign wr     = acc && PWRITE_I;
    assign mapped = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= toc_pkg::OFS_IRQ_MASK);
    // Shadows of run bit and mask, since the checker cannot see inside
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            run_reg  <= 1'b0;
            mask_reg <= 3'h0;
        end else begin
            if (wr && PADDR_I == toc_pkg::OFS_CTRL) run_reg <= PWDATA_I[toc_pkg::CTRL_RUN_BIT];
            if (wr && PADDR_I == toc_pkg::OFS_IRQ_MASK) mask_reg <= PWDATA_I[2:0];
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    sequence s_mask_off;
        wr && PADDR_I == toc_pkg::OFS_IRQ_MASK && PWDATA_I[2:0] == 3'h0;
    endsequence
    bus_ready_a: assert property (acc |-> PREADY_O) else $error("ready low in access");
    unmapped_err_a: assert property (acc && !mapped |-> PSLVERR_O && PRDATA_O == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (acc && mapped |-> !PSLVERR_O) else $error("error on mapped access");
    stop_high_a: assert property (!run_reg |-> COMPARE_PIN_O) else $error("pin low while stopped");
    pin_fall_run_a: assert property ($fell(COMPARE_PIN_O) |-> run_reg) else $error("pin fell while stopped");
    irq_masked_a: assert property (IRQ_O |-> mask_reg != 3'h0) else $error("irq with all masked");
    irq_sticky_a: assert property (IRQ_O && !(wr && PADDR_I[7:3] == 5'h3) |=> IRQ_O)
        else $error("irq dropped without clear");
    mask_off_a: assert property (s_mask_off |=> !IRQ_O) else $error("irq high after mask off");
endmodule : toc_timer_compare_asserts

bind toc_timer_compare toc_timer_compare_asserts chk_u (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CAPTURE_PIN_I(CAPTURE_PIN_I),
    .COMPARE_PIN_O(COMPARE_PIN_O), .IRQ_O(IRQ_O));

// ===== verif/tb.sv
// Self-checking bench of the compare timer with a small reference model
`timescale 1ns/1ps
module tb;
    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic        cap_pin;
    logic        cmp_pin;
    logic        irq;
    logic        errv;
    logic        init;
    logic [1:0]  act;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rdv;
    int          failures;
    int          cmp_count;
    int          n;
    int          c0;
    int          cval;
    logic [7:0]  zaddr [6] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C};
    toc_timer_compare dut_u (.CLK_I(clk), .RSTN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .CAPTURE_PIN_I(cap_pin), .COMPARE_PIN_O(cmp_pin), .IRQ_O(irq));
    // Clock of 10 ns period
    always #5 clk = ~clk;
    task finish_test;
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // One bus transfer; request held until ready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        rdv  = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, rdv, exp);
    endtask : rd
    // Bounded wait for the interrupt line, settled values afterwards
    task wait_irq;
        n = 0;
        // Look just after each edge, never in the time step that launches the line
        while (irq !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("irq", {31'h0, irq}, 32'h1);
    endtask : wait_irq
    // Reference of the pin level after one match
    function automatic logic exp_pin(input logic [1:0] a, input logic i);
        return (a == toc_pkg::ACT_HIGH) ? 1'b1 : (a == toc_pkg::ACT_LOW) ? 1'b0 : (a == toc_pkg::ACT_TOGGLE) ? !i : i;
    endfunction : exp_pin
    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test();
    end
    // Main sequence
    initial begin
        clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; cap_pin = 1'b0; failures = 0; cmp_count = 0;
        void'($urandom(32'h27A31AEC));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("pin_reset", {31'h0, cmp_pin}, 32'h1);
        foreach (zaddr[i]) rd(zaddr[i], 32'h0, "reset_value");
        rd(toc_pkg::OFS_CMP_HI, {16'h0, toc_pkg::CMP_RESET}, "cmp_reset");
        apb(1'b1, 8'h20, 32'hFFFFFFFF);
        chk("err_wr", {31'h0, errv}, 32'h1);
        rd(8'h22, 32'h0, "unmapped");
        apb(1'b1, toc_pkg::OFS_IRQ_MASK, 32'h4);
        // Effective compare value before the first pair of byte writes
        c0 = int'(toc_pkg::CMP_RESET);
        // Every action code, each with a fresh random compare value
        for (int k = 0; k < 4; k++) begin
            act  = k[1:0];
            init = 1'($urandom_range(1, 0));
            cval = int'($urandom_range(16'hF000, 16'h0100));
            apb(1'b1, toc_pkg::OFS_CMP_LO, {24'h0, cval[7:0]});
            rd(toc_pkg::OFS_CMP_HI, 32'(c0), "cmp_pending");
            rd(toc_pkg::OFS_CMP_LO, {24'h0, cval[7:0]}, "cmp_low_pend");
            apb(1'b1, toc_pkg::OFS_CMP_HI, {24'h0, cval[15:8]});
            rd(toc_pkg::OFS_CMP_HI, 32'(cval), "cmp_full");
            c0 = cval;
            apb(1'b1, toc_pkg::OFS_COUNTER, 32'(cval - 3));
            apb(1'b1, toc_pkg::OFS_MODE, {24'h0, 1'b1, 4'h0, init, act});
            apb(1'b1, toc_pkg::OFS_MODE, {29'h0, init, act});
            chk("pin_stopped", {31'h0, cmp_pin}, 32'h1);
            // Pin takes the preset level once the run starts, as the preset port latch would
            apb(1'b1, toc_pkg::OFS_CTRL, 32'h1);
            chk("pin_initial", {31'h0, cmp_pin}, {31'h0, init});
            wait_irq();
            chk("pin_match", {31'h0, cmp_pin}, {31'h0, exp_pin(act, init)});
            apb(1'b1, toc_pkg::OFS_IRQ_STAT, 32'h7);
            repeat (20) @(posedge clk);
            #1;
            chk("single_match", {31'h0, irq}, 32'h0);
            // A second match would toggle the pin back in toggle mode
            chk("pin_once", {31'h0, cmp_pin}, {31'h0, exp_pin(act, init)});
            apb(1'b1, toc_pkg::OFS_CTRL, 32'h0);
        end
        // Top value: sticky status while masked, counting goes on
        apb(1'b1, toc_pkg::OFS_IRQ_MASK, 32'h0);
        apb(1'b1, toc_pkg::OFS_COUNTER, 32'h0000FFFD);
        apb(1'b1, toc_pkg::OFS_CTRL, 32'h1);
        repeat (10) @(posedge clk);
        #1;
        chk("irq_masked", {31'h0, irq}, 32'h0);
        rd(toc_pkg::OFS_IRQ_STAT, 32'h1, "stat_top");
        apb(1'b0, toc_pkg::OFS_COUNTER, 32'h0);
        chk("wrapped", {31'h0, rdv > 0 && rdv < 64}, 32'h1);
        apb(1'b1, toc_pkg::OFS_IRQ_MASK, 32'h1);
        chk("irq_unmasked", {31'h0, irq}, 32'h1);
        apb(1'b1, toc_pkg::OFS_IRQ_STAT, 32'h1);
        chk("irq_cleared", {31'h0, irq}, 32'h0);
        // Capture on rising, then falling, then either edge; pin toggles each pass
        apb(1'b1, toc_pkg::OFS_IRQ_MASK, 32'h2);
        for (int e = 1; e < 4; e++) begin
            apb(1'b1, toc_pkg::OFS_MODE, 32'(e << toc_pkg::MODE_CAP_LSB));
            apb(1'b0, toc_pkg::OFS_COUNTER, 32'h0);
            c0 = int'(rdv);
            chk("cap_idle", {31'h0, irq}, 32'h0);
            @(posedge clk);
            cap_pin <= !cap_pin;
            wait_irq();
            apb(1'b0, toc_pkg::OFS_COUNTER, 32'h0);
            cval = int'(rdv);
            apb(1'b0, toc_pkg::OFS_CAPTURE, 32'h0);
            chk("cap_window", {31'h0, int'(rdv) > c0 && int'(rdv) < cval}, 32'h1);
            rd(toc_pkg::OFS_IRQ_STAT, 32'h2, "stat_cap");
            apb(1'b1, toc_pkg::OFS_IRQ_STAT, 32'h2);
        end
        // Divided rate: select 2 ticks every fourth cycle, ten ticks by the read
        apb(1'b1, toc_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, toc_pkg::OFS_COUNTER, 32'h0);
        apb(1'b1, toc_pkg::OFS_CTRL, 32'h5);
        repeat (40) @(posedge clk);
        rd(toc_pkg::OFS_COUNTER, 32'h0000000A, "prescaled");
        finish_test();
    end
endmodule : tb
